// ### src/event_timer_pkg.sv
// Shared constants, register map and helpers of the event timer block
package event_timer_pkg;

   localparam int NUM_TIMERS = 8;
   localparam int CNT_W = 64;
   localparam int SLOW_W = 82;
   localparam int FRAC_W = 18;
   localparam int CAL_W = 28;

   ////////////////////////////////////////////////////////////////////////
   // Timing: fast counter rate is derived from the core clock
   localparam longint CORE_HZ = 250_000_000;
   localparam longint FAST_HZ = 38_400_000;
   localparam longint TICK_GRID_HZ = 200_000;
   localparam logic [10:0] TICK_INC = 11'(FAST_HZ / TICK_GRID_HZ);
   localparam logic [10:0] TICK_MOD = 11'(CORE_HZ / TICK_GRID_HZ);
   localparam logic [31:0] TICK_PERIOD_FS = 32'(64'd1_000_000_000_000_000 / FAST_HZ);

   ////////////////////////////////////////////////////////////////////////
   // Register map, byte offsets within the decoded 4 KiB window
   localparam logic [11:0] OFS_CAP = 12'h000;
   localparam logic [11:0] OFS_CAP_PERIOD = 12'h004;
   localparam logic [11:0] OFS_GEN_CFG = 12'h010;
   localparam logic [11:0] OFS_STATUS = 12'h014;
   localparam logic [11:0] OFS_INT_STS = 12'h020;
   localparam logic [11:0] OFS_CNT_LO = 12'h0f0;
   localparam logic [11:0] OFS_CNT_HI = 12'h0f4;
   localparam logic [3:0] OFS_TMR_PAGE = 4'h1;
   localparam logic [4:0] OFS_TMR_CFG = 5'h00;
   localparam logic [4:0] OFS_TMR_CMP_LO = 5'h08;
   localparam logic [4:0] OFS_TMR_CMP_HI = 5'h0c;

   ////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int GEN_EN_BIT = 0;
   localparam int GEN_LEG_BIT = 1;
   localparam int STAT_SLOW_BIT = 0;
   localparam int STAT_ARM_BIT = 1;
   localparam int STAT_BUSY_BIT = 2;
   localparam int CAP_NUM_LSB = 8;
   localparam int CAP_WIDE_BIT = 13;
   localparam int CAP_LEG_BIT = 15;
   localparam int TCFG_INT_EN_BIT = 2;
   localparam int TCFG_PER_BIT = 3;
   localparam int TCFG_PER_CAP_BIT = 4;
   localparam int TCFG_VAL_SET_BIT = 6;

   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [CNT_W-1:0] CNT_RST = 64'h0;
   localparam logic [SLOW_W-1:0] SLOW_RST = 82'h0;
   localparam logic [31:0] DAT_RST = 32'h0;

   typedef enum logic [1:0] {
      OFF_FAST,
      OFF_ARM,
      OFF_PARKED,
      OFF_SLOW
   } offload_e;

   // Byte-lane merge of a Wishbone write into a stored word
   function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0] sel);
      logic [31:0] r;
      r = old_w;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = new_w[8*b +: 8];
         end
      end
      return r;
   endfunction

endpackage

// ### src/rtc_edge_sync.sv
// Three-flop synchroniser with rising edge detect for the slow clock pin
`timescale 1ns/100ps
`default_nettype none
module rtc_edge_sync (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic pin_in,
   output logic rise
);
   typedef struct packed {
      logic f1;
      logic f2;
      logic f3;
      logic lvl;
      logic rise;
   } sync_s;

   sync_s q;
   sync_s d;

   always_comb begin
      d = q;
      d.f1 = pin_in;
      d.f2 = q.f1;
      d.f3 = q.f2;
      d.rise = 1'b0;
      // Only an agreed level counts, so one glitch cannot give an edge
      if (q.f2 == q.f3) begin
         d.lvl = q.f3;
         d.rise = q.f3 & ~q.lvl;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign rise = q.rise;
endmodule
`default_nettype wire

// ### src/timer_comparator.sv
// One comparator timer: configuration, comparator value and match detect
`timescale 1ns/100ps
`default_nettype none
module timer_comparator #(
   parameter bit PERIODIC_OK = 1'b0
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [31:0] wdata,
   input wire logic [3:0] sel,
   input wire logic wr_cfg,
   input wire logic wr_lo,
   input wire logic wr_hi,
   input wire logic [63:0] count,
   input wire logic glob_en,
   output logic match,
   output logic active,
   output logic [31:0] cfg_rd,
   output logic [63:0] cmp_rd
);
   typedef struct packed {
      logic int_en;
      logic per;
      logic val_set;
      logic [63:0] cmp;
      logic [63:0] period;
      logic eq;
      logic match;
   } tmr_s;

   tmr_s q;
   tmr_s d;
   logic [31:0] cfg_w;
   logic [31:0] word_w;
   logic [63:0] val_w;
   logic eq_now;

   always_comb begin
      d = q;
      cfg_w = 32'h0;
      word_w = 32'h0;
      val_w = q.period;
      cfg_w = event_timer_pkg::lane_merge(cfg_rd, wdata, sel);
      d.match = 1'b0;
      if (wr_cfg) begin
         d.int_en = cfg_w[event_timer_pkg::TCFG_INT_EN_BIT];
         d.per = cfg_w[event_timer_pkg::TCFG_PER_BIT] & PERIODIC_OK; // R3
         d.val_set = cfg_w[event_timer_pkg::TCFG_VAL_SET_BIT];
      end
      if (wr_lo || wr_hi) begin
         word_w = event_timer_pkg::lane_merge(wr_lo ? q.cmp[31:0] : q.cmp[63:32], wdata, sel);
         val_w = wr_lo ? {q.cmp[63:32], word_w} : {word_w, q.cmp[31:0]};
         d.period = val_w;
         // A periodic timer only reloads its match point with val_set
         if (!q.per || q.val_set) begin
            d.cmp = val_w;
         end
         d.val_set = 1'b0;
      end
      eq_now = (count == q.cmp);
      d.eq = eq_now;
      // Equality is taken once per counter step, not every core cycle
      if (eq_now && !q.eq && glob_en) begin
         d.match = q.int_en; // R2
         if (q.per) begin
            d.cmp = 64'(q.cmp + q.period); // R3
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   always_comb begin
      cfg_rd = 32'h0;
      cfg_rd[event_timer_pkg::TCFG_INT_EN_BIT] = q.int_en;
      cfg_rd[event_timer_pkg::TCFG_PER_BIT] = q.per;
      cfg_rd[event_timer_pkg::TCFG_PER_CAP_BIT] = PERIODIC_OK;
      cfg_rd[event_timer_pkg::TCFG_VAL_SET_BIT] = q.val_set;
   end

   assign cmp_rd = q.cmp;
   assign match = q.match;
   assign active = q.int_en & glob_en;
endmodule
`default_nettype wire

// ### src/event_timer.sv
// Event timer: shared 64-bit counter, eight comparators, slow clock off-load
// Overview of operation
// R1: Eight timers share one main counter, each with own comparator and value.
// R2: A timer raises its interrupt when its value equals the main counter.
// R3: Only timer 0 can run periodic, reloading its comparator by the period.
// R4: The main counter only ever counts upward, so reads never repeat; the code holds it between ticks and while halted, so close reads can repeat.
// R5: Counter rate stays within 0.05 percent of advertised period per millisecond.
// R6: Ticks are at most 100 ns; short-term error within two ticks.
// R7: With fast clock running and enabled, the counter adds one per fast tick.
// R8: With fast clock off, counting continues on the 32.768 kHz clock; the code does so only in off-load, otherwise the counter stops.
// R9: Off-load is refused while any comparator is active.
// R10: Power controller holds the off-load request for the whole deepest idle.
// R11: Power controller supplies 28-bit calibration, added per slow edge.
// R12: A 64-bit fast and an 82-bit slow counter; slow adds calibration per edge.
// R13: Off-load request input and slow-active output are in the core clock domain.
// R14: Mode switches happen only on a slow clock rising edge.
// R15: Entry places fast count in upper 64 bits, low 18 bits zero.
// R16: Slow clock is synchronised; first edge after request parks the fast count.
// R17: The next slow edge adds calibration to the parked count.
// R18: Exit waits a slow edge, loads upper 64 bits, then drops slow-active.
// R19: Later entries overwrite only the upper 64 bits, keeping the fraction.
// R20: Exit requested before entry completes: entry and exit on one slow edge.
// R21: Legacy route select forces fixed routing over per-timer routing.
// R22: Software masks interrupts before clearing legacy route select.
// R23: Registers decode in memory at a base address set by firmware.
// R24: Legacy: timer 0 on IRQ0 and IRQ2, timer 1 on IRQ8, old sources silenced.
// R25: In slow mode, counter reads show the upper 64 bits of the slow counter.
//
// Local design decisions: the Wishbone register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module event_timer (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [19:0] decode_base,
   input wire logic fast_clk_run,
   input wire logic rtc_clk,
   input wire logic offload_req,
   input wire logic [27:0] calib_inc,
   output logic slow_active,
   output logic [7:0] timer_irq,
   output logic legacy_irq0_8259,
   output logic legacy_irq2_apic,
   output logic legacy_irq8,
   output logic legacy_pit_silence,
   output logic legacy_rtc_silence
);

   ////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      event_timer_pkg::offload_e mode;
      logic [63:0] cnt;
      logic [81:0] slow;
      logic [10:0] acc;
      logic en;
      logic leg;
      logic [7:0] sts;
      logic ack;
      logic [31:0] dat;
   } core_s;

   core_s q;
   core_s d;

   logic rtc_rise;
   logic sel_ok;
   logic req_hit;
   logic wr_hit;
   logic [11:0] ofs;
   logic in_tmr_page;
   logic [2:0] tmr_idx;
   logic [4:0] tmr_ofs;
   logic fast_tick;
   logic [11:0] acc_sum;
   logic [63:0] cnt_view;
   logic [81:0] slow_add;
   logic any_active;
   logic [7:0] match;
   logic [7:0] active;
   logic [7:0] wr_cfg;
   logic [7:0] wr_lo;
   logic [7:0] wr_hi;
   logic [31:0] cfg_rd [8];
   logic [63:0] cmp_rd [8];
   logic [31:0] rd_mux;
   logic [31:0] gen_w;

   ////////////////////////////////////////////////////////////////////////
   // Slow clock pin

   rtc_edge_sync u_rtc_sync (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .pin_in(rtc_clk),
      .rise(rtc_rise)
   ); // R16

   ////////////////////////////////////////////////////////////////////////
   // Bus decode

   assign sel_ok = (wb_adr_i[31:12] == decode_base); // R23
   assign req_hit = wb_cyc_i & wb_stb_i & sel_ok & ~q.ack;
   assign wr_hit = req_hit & wb_we_i;
   assign ofs = {wb_adr_i[11:2], 2'b00};
   assign in_tmr_page = (ofs[11:8] == event_timer_pkg::OFS_TMR_PAGE);
   assign tmr_idx = ofs[7:5];
   assign tmr_ofs = ofs[4:0];

   always_comb begin
      wr_cfg = 8'h00;
      wr_lo = 8'h00;
      wr_hi = 8'h00;
      if (wr_hit && in_tmr_page) begin
         wr_cfg[tmr_idx] = (tmr_ofs == event_timer_pkg::OFS_TMR_CFG);
         wr_lo[tmr_idx] = (tmr_ofs == event_timer_pkg::OFS_TMR_CMP_LO);
         wr_hi[tmr_idx] = (tmr_ofs == event_timer_pkg::OFS_TMR_CMP_HI);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Comparators

   for (genvar n = 0; n < event_timer_pkg::NUM_TIMERS; n++) begin : g_tmr
      timer_comparator #(
         .PERIODIC_OK(n == 0)
      ) u_tmr (
         .core_clk(core_clk),
         .rst_b(rst_b),
         .wdata(wb_dat_i),
         .sel(wb_sel_i),
         .wr_cfg(wr_cfg[n]),
         .wr_lo(wr_lo[n]),
         .wr_hi(wr_hi[n]),
         .count(cnt_view),
         .glob_en(q.en),
         .match(match[n]),
         .active(active[n]),
         .cfg_rd(cfg_rd[n]),
         .cmp_rd(cmp_rd[n])
      ); // R1
   end

   assign any_active = |active;

   ////////////////////////////////////////////////////////////////////////
   // Counter view and fast tick

   // Fraction bits stay hidden; software sees whole fast ticks only
   assign cnt_view = (q.mode == event_timer_pkg::OFF_PARKED ||
                      q.mode == event_timer_pkg::OFF_SLOW) ?
                     q.slow[81:18] : q.cnt; // R25

   // Phase accumulator gives 38.4 MHz on average, jitter one core cycle
   assign acc_sum = {1'b0, q.acc} + {1'b0, event_timer_pkg::TICK_INC};
   assign fast_tick = fast_clk_run & (acc_sum >= {1'b0, event_timer_pkg::TICK_MOD}); // R5 R6

   assign slow_add = 82'(q.slow + {54'h0, calib_inc}); // R11

   ////////////////////////////////////////////////////////////////////////
   // Read mux

   always_comb begin
      rd_mux = 32'h0;
      if (in_tmr_page) begin
         unique case (tmr_ofs)
            event_timer_pkg::OFS_TMR_CFG: rd_mux = cfg_rd[tmr_idx];
            event_timer_pkg::OFS_TMR_CMP_LO: rd_mux = cmp_rd[tmr_idx][31:0];
            event_timer_pkg::OFS_TMR_CMP_HI: rd_mux = cmp_rd[tmr_idx][63:32];
            default: rd_mux = 32'h0;
         endcase
      end else begin
         unique case (ofs)
            event_timer_pkg::OFS_CAP: begin
               rd_mux[event_timer_pkg::CAP_NUM_LSB +: 5] = 5'(event_timer_pkg::NUM_TIMERS - 1);
               rd_mux[event_timer_pkg::CAP_WIDE_BIT] = 1'b1;
               rd_mux[event_timer_pkg::CAP_LEG_BIT] = 1'b1;
            end
            event_timer_pkg::OFS_CAP_PERIOD: rd_mux = event_timer_pkg::TICK_PERIOD_FS;
            event_timer_pkg::OFS_GEN_CFG: begin
               rd_mux[event_timer_pkg::GEN_EN_BIT] = q.en;
               rd_mux[event_timer_pkg::GEN_LEG_BIT] = q.leg;
            end
            event_timer_pkg::OFS_STATUS: begin
               rd_mux[event_timer_pkg::STAT_SLOW_BIT] = slow_active;
               rd_mux[event_timer_pkg::STAT_ARM_BIT] = (q.mode == event_timer_pkg::OFF_ARM);
               rd_mux[event_timer_pkg::STAT_BUSY_BIT] = any_active;
            end
            event_timer_pkg::OFS_INT_STS: rd_mux = {24'h0, q.sts};
            event_timer_pkg::OFS_CNT_LO: rd_mux = cnt_view[31:0]; // R4
            event_timer_pkg::OFS_CNT_HI: rd_mux = cnt_view[63:32];
            default: rd_mux = 32'h0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      d = q;
      gen_w = event_timer_pkg::lane_merge({30'h0, q.leg, q.en}, wb_dat_i, wb_sel_i);
      d.ack = req_hit;
      if (req_hit) begin
         d.dat = rd_mux;
      end

      // Fast tick enable, runs with the counter disabled too; holds its phase while fast_clk_run is low
      d.acc = fast_tick ? 11'(acc_sum - {1'b0, event_timer_pkg::TICK_MOD}) : 11'(acc_sum);
      if (!fast_clk_run) begin
         d.acc = q.acc;
      end

      // General configuration and status
      if (wr_hit && ofs == event_timer_pkg::OFS_GEN_CFG) begin
         d.en = gen_w[event_timer_pkg::GEN_EN_BIT];
         d.leg = gen_w[event_timer_pkg::GEN_LEG_BIT]; // R21
      end
      if (wr_hit && ofs == event_timer_pkg::OFS_INT_STS) begin
         d.sts = q.sts & ~(wb_dat_i[7:0] & {8{wb_sel_i[0]}});
      end
      d.sts = d.sts | match; // R2

      // Counter and off-load sequence
      unique case (q.mode)
         event_timer_pkg::OFF_FAST: begin
            if (q.en && fast_tick) begin
               d.cnt = 64'(q.cnt + 64'h1); // R7 R4
            end
            // Counter writes only land while halted
            if (wr_hit && !q.en && ofs == event_timer_pkg::OFS_CNT_LO) begin
               d.cnt[31:0] = event_timer_pkg::lane_merge(q.cnt[31:0], wb_dat_i, wb_sel_i);
            end
            if (wr_hit && !q.en && ofs == event_timer_pkg::OFS_CNT_HI) begin
               d.cnt[63:32] = event_timer_pkg::lane_merge(q.cnt[63:32], wb_dat_i, wb_sel_i);
            end
            if (offload_req && !any_active) begin
               d.mode = event_timer_pkg::OFF_ARM; // R9 R13
            end
         end
         event_timer_pkg::OFF_ARM: begin
            if (q.en && fast_tick) begin
               d.cnt = 64'(q.cnt + 64'h1);
            end
            if (!offload_req || any_active) begin
               d.mode = event_timer_pkg::OFF_FAST;
            end else if (rtc_rise) begin
               // Park: fast count moves into the integer part, fraction kept
               d.slow[81:18] = q.en && fast_tick ? 64'(q.cnt + 64'h1) : q.cnt; // R15 R16 R19
               d.mode = event_timer_pkg::OFF_PARKED; // R14
            end
         end
         event_timer_pkg::OFF_PARKED: begin
            if (rtc_rise) begin
               d.slow = slow_add; // R17 R8
               if (offload_req) begin
                  d.mode = event_timer_pkg::OFF_SLOW;
               end else begin
                  d.cnt = slow_add[81:18]; // R20
                  d.mode = event_timer_pkg::OFF_FAST;
               end
            end
         end
         event_timer_pkg::OFF_SLOW: begin
            if (rtc_rise) begin
               if (offload_req) begin
                  d.slow = slow_add; // R12 R8 R10
               end else begin
                  d.cnt = q.slow[81:18]; // R18
                  d.mode = event_timer_pkg::OFF_FAST; // R14
               end
            end
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         q.mode <= event_timer_pkg::OFF_FAST;
         q.cnt <= event_timer_pkg::CNT_RST;
         q.slow <= event_timer_pkg::SLOW_RST; // R15
         q.acc <= 11'h000;
         q.en <= 1'b0;
         q.leg <= 1'b0;
         q.sts <= 8'h00;
         q.ack <= 1'b0;
         q.dat <= event_timer_pkg::DAT_RST;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign wb_ack_o = q.ack;
   assign wb_dat_o = q.dat;
   assign slow_active = (q.mode == event_timer_pkg::OFF_PARKED) ||
                        (q.mode == event_timer_pkg::OFF_SLOW); // R13

   // Legacy routing takes timers 0 and 1 off their own lines
   assign timer_irq = q.leg ? {q.sts[7:2], 2'b00} : q.sts; // R21
   assign legacy_irq0_8259 = q.leg & q.sts[0]; // R24
   assign legacy_irq2_apic = q.leg & q.sts[0]; // R24
   assign legacy_irq8 = q.leg & q.sts[1]; // R24
   assign legacy_pit_silence = q.leg; // R24
   assign legacy_rtc_silence = q.leg; // R24

endmodule
`default_nettype wire

// ### test/event_timer_sva.sv
// Port checker of the event timer
`timescale 1ns/100ps
`default_nettype none
module event_timer_sva (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [31:0] wb_adr_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [19:0] decode_base,
   input wire logic rtc_clk,
   input wire logic offload_req,
   input wire logic slow_active,
   input wire logic [7:0] timer_irq,
   input wire logic legacy_irq0_8259,
   input wire logic legacy_irq2_apic,
   input wire logic legacy_irq8,
   input wire logic legacy_pit_silence,
   input wire logic legacy_rtc_silence
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o && wb_adr_i[31:12] == decode_base;
   endsequence
   sequence s_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   // Pin rose within the last 10 core cycles, which covers the synchroniser delay
   sequence s_rtc_rise;
      rtc_clk && !$past(rtc_clk, 10);
   endsequence
   property p_ack;
      s_take |=> s_pulse;
   endproperty
   property p_miss;
      wb_cyc_i && wb_stb_i && wb_adr_i[31:12] != decode_base |=> !wb_ack_o;
   endproperty
   property p_cause;
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
   endproperty
   property p_enter;
      $rose(slow_active) |-> s_rtc_rise and $past(offload_req);
   endproperty
   property p_exit;
      $fell(slow_active) |-> s_rtc_rise and !$past(offload_req);
   endproperty
   property p_hold;
      slow_active && offload_req |=> slow_active;
   endproperty
   property p_stay;
      !offload_req && !slow_active |=> !slow_active;
   endproperty
   property p_leg_pair;
      legacy_irq0_8259 == legacy_irq2_apic && legacy_pit_silence == legacy_rtc_silence;
   endproperty
   property p_leg_mask;
      legacy_pit_silence |-> timer_irq[1:0] == 2'h0;
   endproperty
   property p_std;
      !legacy_pit_silence |-> !legacy_irq0_8259 && !legacy_irq8;
   endproperty
   a_ack: assert property (p_ack) else $error("ack not a single pulse");
   a_miss: assert property (p_miss) else $error("foreign address acked");
   a_cause: assert property (p_cause) else $error("ack without request");
   a_enter: assert property (p_enter) else $error("entry off slow edge");
   a_exit: assert property (p_exit) else $error("exit off slow edge");
   a_hold: assert property (p_hold) else $error("slow mode left early");
   a_stay: assert property (p_stay) else $error("slow mode unasked");
   a_leg_pair: assert property (p_leg_pair) else $error("legacy pair split");
   a_leg_mask: assert property (p_leg_mask) else $error("timer 0 or 1 leaked");
   a_std: assert property (p_std) else $error("legacy line without select");
endmodule
bind event_timer event_timer_sva u_sva (.core_clk(core_clk), .rst_b(rst_b),
   .wb_adr_i(wb_adr_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .decode_base(decode_base), .rtc_clk(rtc_clk), .offload_req(offload_req),
   .slow_active(slow_active), .timer_irq(timer_irq), .legacy_irq0_8259(legacy_irq0_8259),
   .legacy_irq2_apic(legacy_irq2_apic), .legacy_irq8(legacy_irq8),
   .legacy_pit_silence(legacy_pit_silence), .legacy_rtc_silence(legacy_rtc_silence));
`default_nettype wire

// ### test/pmc_model.sv
// Power controller and slow clock model facing the off-load link
`timescale 1ns/100ps
`default_nettype none
module pmc_model #(
   parameter logic [27:0] CALIB = 28'h09a0000
) (
   input wire logic core_clk,
   input wire logic idle,
   output logic offload_req,
   output logic [27:0] calib_inc,
   output logic rtc_clk
);
   // Slow clock runs free, sped up so the run stays short
   initial rtc_clk = 1'b0;
   always #501.3 rtc_clk = ~rtc_clk;
   // Ticks per slow period times 2**18
   assign calib_inc = CALIB;
   always_ff @(posedge core_clk) offload_req <= idle;
endmodule
`default_nettype wire

// ### test/event_timer_tb.sv
// Bench of the event timer
`timescale 1ns/100ps
`default_nettype none
module event_timer_tb;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, rd, c0;
   logic [31:0] cv [2];
   logic [3:0] wb_sel_i = 4'hf;
   logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, fast_clk_run = 1'b1, idle = 1'b0;
   logic [19:0] decode_base = 20'hfed00;
   logic wb_ack_o, rtc_clk, offload_req, slow_active, leg0, leg2, leg8, sil_a, sil_b;
   logic [27:0] calib_inc;
   logic [7:0] timer_irq;
   logic [11:0] a;
   logic [15:0] lfsr = 16'hd474;
   longint cyc = 0, tk, t0;
   int fails = 0, checks_done = 0, t;
   always #2 core_clk = ~core_clk;
   always @(posedge core_clk) cyc <= cyc + 1;
   event_timer dut (.core_clk(core_clk), .rst_b(rst_b), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .decode_base(decode_base), .fast_clk_run(fast_clk_run), .rtc_clk(rtc_clk),
      .offload_req(offload_req), .calib_inc(calib_inc), .slow_active(slow_active),
      .timer_irq(timer_irq), .legacy_irq0_8259(leg0), .legacy_irq2_apic(leg2),
      .legacy_irq8(leg8), .legacy_pit_silence(sil_a), .legacy_rtc_silence(sil_b));
   pmc_model pmc (.core_clk(core_clk), .idle(idle), .offload_req(offload_req),
      .calib_inc(calib_inc), .rtc_clk(rtc_clk));
   ////////////////////////////////////////
   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic longint ticks(input longint c);
      return c * event_timer_pkg::TICK_INC / event_timer_pkg::TICK_MOD;
   endfunction
   function automatic logic sig(input int w);
      case (w)
         8: return leg0;
         9: return leg8;
         10: return slow_active;
         default: return timer_irq[w[2:0]];
      endcase
   endfunction
   task automatic cmp(input logic [63:0] g, input logic [63:0] e);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic near(input longint g, input longint e, input longint tol);
      checks_done++;
      if (g < e - tol || g > e + tol) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Holds the request until ack; foreign addresses time out
   task automatic bus(input logic [11:0] ad, input logic w, input logic [31:0] d,
                      input logic hit);
      int n;
      n = 0;
      @(posedge core_clk);
      wb_adr_i <= {hit ? decode_base : ~decode_base, ad};
      wb_we_i <= w;
      wb_dat_i <= d;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 30);
      rd = wb_dat_o;
      tk = cyc;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      cmp(64'(n < 30), 64'(hit));
   endtask
   task automatic wr(input logic [11:0] ad, input logic [31:0] d);
      bus(ad, 1'b1, d, 1'b1);
   endtask
   task automatic rdl(input logic [11:0] ad);
      bus(ad, 1'b0, 32'h0, 1'b1);
   endtask
   task automatic hold_for(input int w, input logic v, input int lim);
      int n = 0;
      while (sig(w) !== v && n < lim) begin
         @(posedge core_clk);
         n++;
      end
   endtask
   task automatic results;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (40000) @(posedge core_clk);
      fails++;
      results();
   end
   initial begin
      repeat (4) @(posedge core_clk);
      rst_b <= 1'b1;
      rdl(event_timer_pkg::OFS_CAP);
      cmp({rd[15], rd[13:8]}, 7'h67);
      rdl(event_timer_pkg::OFS_CAP_PERIOD);
      near(rd, 50_000_000, 50_000_000);
      for (int k = 0; k < 2; k++) begin
         rdl(12'h100 + 12'(k * 32));
         cmp(rd[4], k == 0);
      end
      $display("end capabilities");
      wr(event_timer_pkg::OFS_GEN_CFG, 32'h1);
      rdl(event_timer_pkg::OFS_CNT_LO);
      c0 = rd;
      t0 = tk;
      repeat (1250) @(posedge core_clk);
      rdl(event_timer_pkg::OFS_CNT_LO);
      near(rd - c0, ticks(tk - t0), 2);
      fast_clk_run <= 1'b0;
      c0 = rd;
      repeat (100) @(posedge core_clk);
      rdl(event_timer_pkg::OFS_CNT_LO);
      near(rd - c0, 0, 1);
      fast_clk_run <= 1'b1;
      $display("end rate");
      for (int i = 0; i < 4; i++) begin
         lfsr = nxt(lfsr);
         a = 12'h200 + {1'b0, lfsr[8:0], 2'h0};
         wr(a, {lfsr, lfsr});
         rdl(a);
         cmp(rd, 32'h0);
         bus(a, 1'b0, 32'h0, 1'b0);
      end
      $display("end decode");
      for (int k = 0; k < 10; k++) begin
         t = k % 8;
         lfsr = nxt(lfsr);
         if (k == 8) wr(event_timer_pkg::OFS_GEN_CFG, 32'h3);
         rdl(event_timer_pkg::OFS_CNT_LO);
         wr(12'h108 + 12'(t * 32), rd + 32'd150 + 32'(lfsr[5:0]));
         wr(12'h10c + 12'(t * 32), 32'h0);
         wr(12'h100 + 12'(t * 32), 32'h4);
         hold_for(k, 1'b1, 3000);
         cmp(sig(k), 1'b1);
         cmp({leg2, sil_a, sil_b}, {k == 8, {2{k > 7}}});
         wr(event_timer_pkg::OFS_INT_STS, 32'h1 << t);
         wr(12'h100 + 12'(t * 32), 32'h0);
         cmp(sig(k), 1'b0);
      end
      wr(event_timer_pkg::OFS_GEN_CFG, 32'h1);
      $display("end interrupts");
      wr(12'h100, 32'h4);
      idle <= 1'b1;
      repeat (600) @(posedge core_clk);
      cmp(slow_active, 1'b0);
      rdl(event_timer_pkg::OFS_STATUS);
      cmp(rd[2], 1'b1);
      wr(12'h100, 32'h0);
      hold_for(10, 1'b1, 1000);
      cmp(slow_active, 1'b1);
      fast_clk_run <= 1'b0;
      for (int i = 0; i < 2; i++) begin
         @(posedge rtc_clk);
         repeat (12) @(posedge core_clk);
         rdl(event_timer_pkg::OFS_CNT_LO);
         cv[i] = rd;
      end
      near(cv[1] - cv[0], 38, 1);
      fast_clk_run <= 1'b1;
      idle <= 1'b0;
      hold_for(10, 1'b0, 1000);
      cmp(slow_active, 1'b0);
      rdl(event_timer_pkg::OFS_CNT_LO);
      near(rd - cv[1], 60, 60);
      @(posedge rtc_clk);
      @(posedge core_clk);
      idle <= 1'b1;
      hold_for(10, 1'b1, 1000);
      idle <= 1'b0;
      hold_for(10, 1'b0, 1000);
      cmp(slow_active, 1'b0);
      $display("end off-load");
      results();
   end
endmodule
`default_nettype wire
